// [toh_tx_overhead.sv]
// Transmit overhead insertion, alarm formatting and single-shot error injection
// Notes on behaviour
// (R1) E1 Y16 alarm insertion; hardware forces it off in T1
// (R2) Remote alarm bit owned by alarm formatter
// (R3) Multiframe alignment generated or passed through
// (R4) Auto far-end error low in frames 13/15
// (R5) CRC check bits generated or passed through
// (R6) Frame alignment bits generated per mode
// (R7) Control at zero passes system bits unchanged
// (R8) System supplies framing when frame bits bypassed
// (R9) Each written one other than the slip direction bit injects exactly one error
// (R10) CAS and multiframe bit inversions
// (R11) Invert next PRBS generator bit
// (R12) Alignment shift by one bit for one frame
// (R13) Repeated shifts cause controlled frame slip
// (R14) Invert next CRC bit
// (R15) Invert next frame bit
// (R16) T1 violation waits for two consecutive pulses
// (R17) E1 HDB3 emits two same-polarity violations
// (R18) Three-way far-end bit selection
// (R19) Receive CRC errors held one multiframe
// (R20) Spare bits from buffer when enabled
// (R21) Y16 manual, automatic or pass-through
// (R22) Remote alarm manual, automatic or inactive
// (R23) Code 01 selects HDB3 or B8ZS
// (R24) Single-shot injection bits self-clear
`timescale 1ns/1ps
`default_nettype none
module toh_tx_overhead (
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Register port
    input  wire logic [7:0]              regAddr,
    input  wire logic [7:0]              regWrData,
    input  wire logic                    regWrEn,
    input  wire logic                    regRdEn,
    output logic [7:0]                   regRdData,
    // Mode
    input  wire logic                    t1NotE1Select,
    input  wire logic [1:0]              txZeroSuppressionSelect,
    // Receive status
    input  wire logic                    rxFrameAlignLost,
    input  wire logic                    rxCasAlignLost,
    input  wire logic                    rxCrcErrSmf1,
    input  wire logic                    rxCrcErrSmf2,
    // Transmit multiframe boundary
    input  wire logic                    txMfStart,
    // Incoming slot stream from the slip buffer and formatters
    input  wire toh_pkg::toh_slot_info_t slotIn,
    input  wire logic                    slotValid,
    output logic                         slotReady,
    input  wire logic [4:0]              spareBufBits,
    // Line stream
    output toh_pkg::toh_line_t           lineOut,
    output logic                         lineValid,
    input  wire logic                    lineReady,
    output logic                         alignShiftActive
);
    // =====================================================
    // Registers
    logic [7:0] ovhCtrl_r;
    logic [7:0] spareFe_r;
    logic [7:0] alarmCfg_r;
    logic [7:0] errInj_r;
    logic [7:0] errInjNxt;

    wire wrOvh   = regWrEn && regAddr == toh_pkg::ADDR_OVH_CTRL;
    wire wrInj   = regWrEn && regAddr == toh_pkg::ADDR_ERR_INJ;
    wire wrSpare = regWrEn && regAddr == toh_pkg::ADDR_SPARE_FE;
    wire wrAlarm = regWrEn && regAddr == toh_pkg::ADDR_ALARM_CFG;

    always_comb
    begin
        case (regAddr)
            toh_pkg::ADDR_OVH_CTRL:  regRdData = {2'h0, ovhCtrl_r[5:0]};
            toh_pkg::ADDR_ERR_INJ:   regRdData = errInj_r;
            toh_pkg::ADDR_SPARE_FE:  regRdData = spareFe_r;
            toh_pkg::ADDR_ALARM_CFG: regRdData = {2'h0, alarmCfg_r[5:0]};
            default:                 regRdData = 8'h00;
        endcase
    end

    wire insFbit = ovhCtrl_r[toh_pkg::OVH_FBIT];
    wire insCrc  = ovhCtrl_r[toh_pkg::OVH_CRC];
    wire insFe   = ovhCtrl_r[toh_pkg::OVH_FE];
    wire insMf   = ovhCtrl_r[toh_pkg::OVH_MF];
    wire insYel  = ovhCtrl_r[toh_pkg::OVH_YEL];
    wire insMyel = ovhCtrl_r[toh_pkg::OVH_MYEL];
    wire slipDir = errInj_r[toh_pkg::INJ_SLIP];

    // =====================================================
    // Slot classification, decoded combinationally from slotIn
    wire toh_pkg::toh_slot_info_t s = slotIn;
    wire take = slotValid && slotReady;
    wire isFrame = s.kind == toh_pkg::SLOT_FRAME;
    wire isMf    = s.kind == toh_pkg::SLOT_MF;
    wire isCrc   = s.kind == toh_pkg::SLOT_CRC;
    wire isFe    = s.kind == toh_pkg::SLOT_FE;
    wire isYel   = s.kind == toh_pkg::SLOT_YEL;
    wire isCas   = s.kind == toh_pkg::SLOT_CAS_MF;
    wire isPrbs  = s.kind == toh_pkg::SLOT_PRBS;

    // =====================================================
    // Far-end error latches, held for one full transmit multiframe
    logic feHold1_r;
    logic feHold2_r;
    logic fePend1_r;
    logic fePend2_r;
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            feHold1_r <= 1'b0;
            feHold2_r <= 1'b0;
            fePend1_r <= 1'b0;
            fePend2_r <= 1'b0;
        end
        else
        begin
            // Pending catches errors, hold spans one tx multiframe [R19]
            fePend1_r <= rxCrcErrSmf1 || (fePend1_r && !txMfStart);
            fePend2_r <= rxCrcErrSmf2 || (fePend2_r && !txMfStart);
            if (txMfStart)
            begin
                feHold1_r <= fePend1_r || rxCrcErrSmf1;
                feHold2_r <= fePend2_r || rxCrcErrSmf2;
            end
        end
    end

    // =====================================================
    // Overhead selection
    wire isFe13 = isFe && s.frameNum == toh_pkg::FRM_FE13;
    wire feAuto = isFe13 ? !feHold1_r : !feHold2_r;                  // [R4]
    wire feMan  = isFe13 ? spareFe_r[toh_pkg::FE_BIT13] : spareFe_r[toh_pkg::FE_BIT15];
    wire feBit  = !insFe ? s.sysBit
                : (spareFe_r[toh_pkg::FE_MANUAL] ? feMan : feAuto);  // [R18]

    wire yelOn  = alarmCfg_r[toh_pkg::ALM_MANY]
               || (alarmCfg_r[toh_pkg::ALM_AYEL] && rxFrameAlignLost); // [R22]
    wire yelBit = insYel ? (yelOn ? s.fmtBit : s.sysBit) : s.sysBit; // [R2]
    wire myelOn = alarmCfg_r[toh_pkg::ALM_MYEL]
               || (alarmCfg_r[toh_pkg::ALM_AMYEL] && rxCasAlignLost);  // [R21]
    wire myelBit = (insMyel && !t1NotE1Select && myelOn) ? 1'b1 : s.sysBit; // [R1]
    wire spareBit = spareFe_r[toh_pkg::SA_LSB + 32'(s.spareIdx)]
                  ? spareBufBits[s.spareIdx] : s.sysBit;              // [R20]

    logic baseBit;
    always_comb
    begin
        case (s.kind)
            toh_pkg::SLOT_FRAME: baseBit = insFbit ? s.fmtBit : s.sysBit; // [R6] [R7]
            toh_pkg::SLOT_MF:    baseBit = insMf ? s.fmtBit : s.sysBit;   // [R3] [R7]
            toh_pkg::SLOT_CRC:   baseBit = insCrc ? s.fmtBit : s.sysBit;  // [R5] [R7]
            toh_pkg::SLOT_FE:    baseBit = feBit;
            toh_pkg::SLOT_YEL:   baseBit = yelBit;
            toh_pkg::SLOT_MYEL:  baseBit = myelBit;
            toh_pkg::SLOT_SPARE: baseBit = spareBit;
            toh_pkg::SLOT_PRBS:  baseBit = s.fmtBit;
            default:             baseBit = s.sysBit;
        endcase
    end

    // =====================================================
    // Single-shot error application
    wire hitFrm  = errInj_r[toh_pkg::INJ_FRM]  && isFrame; // [R15]
    wire hitCrc  = errInj_r[toh_pkg::INJ_CRC]  && isCrc;   // [R14]
    wire hitMf   = errInj_r[toh_pkg::INJ_MF]   && isMf;    // [R10]
    wire hitCas  = errInj_r[toh_pkg::INJ_CAS]  && isCas;   // [R10]
    wire hitPrbs = errInj_r[toh_pkg::INJ_PRBS] && isPrbs;  // [R11]
    // Alignment shift: T1 drops the frame bit, E1 dir 0 drops the frame or far-end bit, E1 dir 1 adds a one
    wire shiftNow = errInj_r[toh_pkg::INJ_COFA] && (t1NotE1Select ? isFrame
                  : (slipDir ? s.preFas : isFe || isFrame));     // [R12]
    wire outBit = baseBit ^ (hitFrm | hitCrc | hitMf | hitCas | hitPrbs);

    // Line code violation: T1 waits for two consecutive marks
    logic prevMark_r;
    logic lcvSecond_r;
    wire lcvReq   = errInj_r[toh_pkg::INJ_LCV];
    wire hdb3Mode = !t1NotE1Select && txZeroSuppressionSelect == toh_pkg::ZCS_HDB3_B8ZS; // [R23]
    wire lcvT1    = lcvReq && t1NotE1Select && prevMark_r && outBit; // [R16]
    wire lcvE1    = lcvReq && !t1NotE1Select && outBit;              // [R17]
    wire lcvDone  = t1NotE1Select ? lcvT1 : (hdb3Mode ? lcvSecond_r && outBit : lcvE1);

    always_comb
    begin
        errInjNxt = errInj_r;
        if (take)
        begin
            // Applied error bits clear themselves [R24]
            if (hitFrm)   errInjNxt[toh_pkg::INJ_FRM]  = 1'b0;
            if (hitCrc)   errInjNxt[toh_pkg::INJ_CRC]  = 1'b0;
            if (hitMf)    errInjNxt[toh_pkg::INJ_MF]   = 1'b0;
            if (hitCas)   errInjNxt[toh_pkg::INJ_CAS]  = 1'b0;
            if (hitPrbs)  errInjNxt[toh_pkg::INJ_PRBS] = 1'b0;
            if (shiftNow) errInjNxt[toh_pkg::INJ_COFA] = 1'b0;
            if (lcvDone)  errInjNxt[toh_pkg::INJ_LCV]  = 1'b0;    // [R16]
        end
        // Written ones set, zeros ignored; set wins over clear [R9]
        // Slip direction is a plain stored bit, so a zero clears it
        if (wrInj)
        begin
            errInjNxt                    = errInjNxt | regWrData;
            errInjNxt[toh_pkg::INJ_SLIP] = regWrData[toh_pkg::INJ_SLIP];
        end
    end

    // =====================================================
    // Output stage through the FIFO
    toh_pkg::toh_line_t lineNxt;
    always_comb
    begin
        lineNxt           = '0;
        lineNxt.data      = shiftNow ? slipDir : outBit;
        lineNxt.mark      = lineNxt.data;
        lineNxt.violation = (lcvT1 || lcvE1 || (hdb3Mode && lcvSecond_r && outBit)) && !shiftNow;
        lineNxt.suppress  = shiftNow && !(slipDir && !t1NotE1Select); // [R13]
        lineNxt.extraOne  = shiftNow && slipDir && !t1NotE1Select;    // [R13]
    end

    logic fifoInReady;
    assign slotReady = fifoInReady; // Line back-pressure stalls slot intake

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ovhCtrl_r   <= toh_pkg::RST_OVH_CTRL;
            spareFe_r   <= toh_pkg::RST_SPARE_FE;
            alarmCfg_r  <= toh_pkg::RST_ALARM_CFG;
            errInj_r    <= 8'h00;
            prevMark_r  <= 1'b0;
            lcvSecond_r <= 1'b0;
        end
        else
        begin
            if (wrOvh)   ovhCtrl_r  <= regWrData;
            if (wrSpare) spareFe_r  <= regWrData;
            if (wrAlarm) alarmCfg_r <= regWrData;
            errInj_r <= errInjNxt;
            if (take)
            begin
                prevMark_r  <= lineNxt.mark && lcvReq; // Marks before the request do not count [R16]
                lcvSecond_r <= hdb3Mode && lcvE1 && !lcvSecond_r; // [R17]
            end
        end
    end

    assign alignShiftActive = errInj_r[toh_pkg::INJ_COFA];

    toh_fifo #(
        .WIDTH ($bits(toh_pkg::toh_line_t)),
        .DEPTH (toh_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .reset    (reset),
        .inData   (lineNxt),
        .inValid  (slotValid),
        .inReady  (fifoInReady),
        .outData  (lineOut),
        .outValid (lineValid),
        .outReady (lineReady)
    );

    // =====================================================
    // Checks
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);
    chk_frame_inject: assert property ( // [R15]
        take && hitFrm && !shiftNow && !wrInj |-> lineNxt.data != baseBit ##1 !errInj_r[toh_pkg::INJ_FRM])
        else $error("frame bit error not applied once");
    chk_crc_inject: assert property ( // [R14]
        take && hitCrc && !shiftNow |-> lineNxt.data == !baseBit)
        else $error("crc bit not inverted");
    chk_fe_auto: assert property ( // [R18]
        isFe && insFe && !spareFe_r[toh_pkg::FE_MANUAL] && feHold1_r && isFe13 |-> baseBit == 1'b0)
        else $error("automatic far-end bit not low");
    chk_fe_bypass: assert property ( // [R7]
        isFe && !insFe |-> baseBit == s.sysBit)
        else $error("far-end bit not bypassed");
    chk_fe_hold: assert property ( // [R19]
        txMfStart && rxCrcErrSmf1 |=> feHold1_r)
        else $error("crc error not held");
    chk_lcv_pairs: assert property ( // [R16]
        take && t1NotE1Select && lineNxt.violation |-> prevMark_r && lineNxt.data)
        else $error("violation without two marks");
    chk_inj_write: assert property ( // [R9]
        wrInj && regWrData[toh_pkg::INJ_CRC] |=> errInj_r[toh_pkg::INJ_CRC])
        else $error("injection request lost");
    chk_yel_manual: assert property ( // [R22]
        isYel && insYel && alarmCfg_r[toh_pkg::ALM_MANY] |-> baseBit == s.fmtBit)
        else $error("remote alarm not sent");
endmodule
`default_nettype wire

// [toh_pkg.sv]
// Package: register map, field positions and shared types for tx overhead block
package toh_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_OVH_CTRL  = 8'h72;
    localparam logic [7:0] ADDR_ERR_INJ   = 8'h73;
    localparam logic [7:0] ADDR_SPARE_FE  = 8'h74;
    localparam logic [7:0] ADDR_ALARM_CFG = 8'h75;
    // Reset values
    localparam logic [7:0] RST_OVH_CTRL   = 8'h00;
    localparam logic [7:0] RST_SPARE_FE   = 8'h00;
    localparam logic [7:0] RST_ALARM_CFG  = 8'h00;
    // Overhead control fields
    localparam int OVH_FBIT  = 0;
    localparam int OVH_CRC   = 1;
    localparam int OVH_FE    = 2;
    localparam int OVH_MF    = 3;
    localparam int OVH_YEL   = 4;
    localparam int OVH_MYEL  = 5;
    // Error injection fields
    localparam int INJ_LCV   = 0;
    localparam int INJ_FRM   = 1;
    localparam int INJ_CRC   = 2;
    localparam int INJ_COFA  = 3;
    localparam int INJ_SLIP  = 4;
    localparam int INJ_PRBS  = 5;
    localparam int INJ_MF    = 6;
    localparam int INJ_CAS   = 7;
    // Spare / far-end fields
    localparam int FE_MANUAL = 0;
    localparam int FE_BIT13  = 1;
    localparam int FE_BIT15  = 2;
    localparam int SA_LSB    = 3;
    // Alarm config fields
    localparam int ALM_MYEL  = 2;
    localparam int ALM_AYEL  = 4;
    localparam int ALM_AMYEL = 5;
    localparam int ALM_MANY  = 1;
    // Zero suppression code for HDB3/B8ZS
    localparam logic [1:0] ZCS_HDB3_B8ZS = 2'h1;
    // E1 frame numbers carrying far-end error bits
    localparam logic [3:0] FRM_FE13  = 4'hD;
    localparam logic [3:0] FRM_FE15  = 4'hF;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_WIDTH = 8;

    // Kind of bit in the current line slot
    typedef enum logic [3:0] {
        SLOT_PAYLOAD  = 4'h0,
        SLOT_FRAME    = 4'h1,
        SLOT_MF       = 4'h2,
        SLOT_CRC      = 4'h3,
        SLOT_FE       = 4'h4,
        SLOT_YEL      = 4'h5,
        SLOT_MYEL     = 4'h6,
        SLOT_CAS_MF   = 4'h7,
        SLOT_SPARE    = 4'h8,
        SLOT_PRBS     = 4'h9
    } toh_slot_t;

    // One bit slot of the transmit stream with its framing context
    typedef struct packed {
        toh_slot_t  kind;
        logic       sysBit;
        logic       fmtBit;
        logic [3:0] frameNum;
        logic [2:0] spareIdx;
        logic       preFas;
    } toh_slot_info_t;

    // Line output: bit plus polarity / violation marks
    typedef struct packed {
        logic data;
        logic mark;
        logic violation;
        logic suppress;
        logic extraOne;
    } toh_line_t;
endpackage

// [toh_fifo.sv]
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module toh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic [WIDTH-1:0]      outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    wire              doWrite = inValid && inReady;
    wire              doRead  = outValid && outReady;

    assign inReady  = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData  = mem_r[rdPtr_r];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (doWrite)
            begin
                mem_r[wrPtr_r] <= inData;
                wrPtr_r        <= AW'(wrPtr_r + 1'b1);
            end
            if (doRead)
                rdPtr_r <= AW'(rdPtr_r + 1'b1);
            count_r <= (AW+1)'(count_r + doWrite - doRead);
        end
    end
endmodule
`default_nettype wire

// [toh_far_end.sv]
// Behavioural remote line terminal that takes the transmit line stream
`timescale 1ns/1ps
`default_nettype none
module toh_far_end (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               stall,
    input  wire toh_pkg::toh_line_t lineOut,
    input  wire logic               lineValid,
    output logic                    lineReady
);
    // ==========================================================
    // Receive side
    toh_pkg::toh_line_t rxQ[$];
    int                 violations = 0;

    initial lineReady = 1'b0;

    // Ready moves off the sampling edge
    always @(negedge clk)
    begin
        lineReady <= !stall && !reset;
    end

    // Counts marked violations
    always @(posedge clk)
    begin
        if (!reset && lineValid && lineReady)
        begin
            rxQ.push_back(lineOut);
            if (lineOut.violation === 1'b1)
                violations++;
        end
    end
endmodule
`default_nettype wire

// [tx_overhead_alarm_error_inserter_test.sv]
// Register-driven testbench for the transmit overhead and error inserter
`timescale 1ns/1ps
`default_nettype none
module tx_overhead_alarm_error_inserter_test;
    // ==========================================================
    // Signals
    logic                     clk;
    logic                     reset;
    logic [7:0]               regAddr;
    logic [7:0]               regWrData;
    logic                     regWrEn;
    logic                     regRdEn;
    logic [7:0]               regRdData;
    logic                     t1NotE1Select;
    logic                     rxFrameAlignLost;
    logic                     rxCasAlignLost;
    logic                     rxCrcErrSmf1;
    logic                     rxCrcErrSmf2;
    logic                     txMfStart;
    toh_pkg::toh_slot_info_t  slotIn;
    logic                     slotValid;
    logic                     slotReady;
    logic [4:0]               spareBufBits;
    toh_pkg::toh_line_t       lineOut;
    logic                     lineValid;
    logic                     lineReady;
    logic                     alignShiftActive;
    logic                     stall;
    toh_pkg::toh_line_t       lastLine;
    logic [7:0]               rd;
    int                       numErrors = 0;
    int                       comparisons = 0;
    int                       cycles = 0;
    int                       v0;
    int                       injBit[5] = '{toh_pkg::INJ_FRM, toh_pkg::INJ_CRC, toh_pkg::INJ_MF,
                                            toh_pkg::INJ_CAS, toh_pkg::INJ_PRBS};
    toh_pkg::toh_slot_t       injKind[5] = '{toh_pkg::SLOT_FRAME, toh_pkg::SLOT_CRC, toh_pkg::SLOT_MF,
                                             toh_pkg::SLOT_CAS_MF, toh_pkg::SLOT_PRBS};

    toh_tx_overhead i_toh_tx_overhead (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .t1NotE1Select(t1NotE1Select),
        .txZeroSuppressionSelect(toh_pkg::ZCS_HDB3_B8ZS), .rxFrameAlignLost(rxFrameAlignLost),
        .rxCasAlignLost(rxCasAlignLost), .rxCrcErrSmf1(rxCrcErrSmf1), .rxCrcErrSmf2(rxCrcErrSmf2),
        .txMfStart(txMfStart), .slotIn(slotIn), .slotValid(slotValid), .slotReady(slotReady),
        .spareBufBits(spareBufBits), .lineOut(lineOut), .lineValid(lineValid), .lineReady(lineReady),
        .alignShiftActive(alignShiftActive));
    toh_far_end i_toh_far_end (.clk(clk), .reset(reset), .stall(stall), .lineOut(lineOut),
        .lineValid(lineValid), .lineReady(lineReady));

    always #25 clk = ~clk;

    // ==========================================================
    // Tasks, entered at a falling edge except closeOut when the hang guard calls it on a rising edge
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task closeOut;
        $display("Comparisons %0d, mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task regWrite(input logic [7:0] a, input logic [7:0] d);
        regAddr   = a;
        regWrData = d;
        regWrEn   = 1'b1;
        @(negedge clk);
        regWrEn   = 1'b0;
        @(negedge clk);
    endtask

    task regRead(input logic [7:0] a, output logic [7:0] d);
        regAddr = a;
        regRdEn = 1'b1;
        #1 d    = regRdData;
        @(negedge clk);
        regRdEn = 1'b0;
    endtask

    task sendSlot(input toh_pkg::toh_slot_t k, input logic s, input logic f, input logic [3:0] frm,
                  input logic [2:0] idx, input logic pre);
        slotIn    = '{kind: k, sysBit: s, fmtBit: f, frameNum: frm, spareIdx: idx, preFas: pre};
        slotValid = 1'b1;
        while (slotReady !== 1'b1)
            @(negedge clk);
        @(negedge clk);
        slotValid = 1'b0;
        @(negedge clk);
    endtask

    task getLine;
        int n;
        n = 0;
        while (i_toh_far_end.rxQ.size() == 0 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (i_toh_far_end.rxQ.size() == 0)
            lastLine = 'x;
        else
            lastLine = i_toh_far_end.rxQ.pop_front();
    endtask

    // One slot, judged on its line bit
    task cr(input logic [7:0] ctl, input logic [7:0] spr, input logic [7:0] alm, input toh_pkg::toh_slot_t k,
            input logic s, input logic f, input logic [3:0] frm, input logic [2:0] idx, input logic expBit);
        regWrite(toh_pkg::ADDR_OVH_CTRL, ctl);
        regWrite(toh_pkg::ADDR_SPARE_FE, spr);
        regWrite(toh_pkg::ADDR_ALARM_CFG, alm);
        sendSlot(k, s, f, frm, idx, 1'b0);
        getLine();
        check({7'h00, lastLine.data}, {7'h00, expBit});
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        // Hang guard; run needs a few hundred
        if (cycles == 20000)
        begin
            numErrors++;
            closeOut();
        end
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        clk = 1'b0; reset = 1'b1; regAddr = 8'h00; regWrData = 8'h00; regWrEn = 1'b0; regRdEn = 1'b0;
        t1NotE1Select = 1'b0; rxFrameAlignLost = 1'b0; rxCasAlignLost = 1'b0; rxCrcErrSmf1 = 1'b0;
        rxCrcErrSmf2 = 1'b0; txMfStart = 1'b0; slotIn = '0; slotValid = 1'b0; spareBufBits = 5'h06; stall = 1'b0;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        regRead(toh_pkg::ADDR_OVH_CTRL, rd);  check(rd, toh_pkg::RST_OVH_CTRL);
        regRead(toh_pkg::ADDR_SPARE_FE, rd);  check(rd, toh_pkg::RST_SPARE_FE);
        regRead(toh_pkg::ADDR_ALARM_CFG, rd); check(rd, toh_pkg::RST_ALARM_CFG);
        regWrite(8'h76, 8'hFF); regRead(8'h76, rd); check(rd, 8'h00);
        regWrite(toh_pkg::ADDR_OVH_CTRL, 8'h3F); regRead(toh_pkg::ADDR_OVH_CTRL, rd); check(rd, 8'h3F);
        regWrite(toh_pkg::ADDR_SPARE_FE, 8'hFF); regRead(toh_pkg::ADDR_SPARE_FE, rd); check(rd, 8'hFF);
        regWrite(toh_pkg::ADDR_ALARM_CFG, 8'h36); regRead(toh_pkg::ADDR_ALARM_CFG, rd); check(rd, 8'h36);
        $display("Test registers finished");
        for (int i = 0; i < 3; i++)
        begin
            cr(8'h00, 8'h00, 8'h00, injKind[i], 1'b1, 1'b0, 4'h1, 3'h0, 1'b1);
            cr(8'h01 << (i == 2 ? 3 : i), 8'h00, 8'h00, injKind[i], 1'b1, 1'b0, 4'h1, 3'h0, 1'b0);
        end
        $display("Test overhead insertion finished");
        regWrite(toh_pkg::ADDR_ERR_INJ, 8'h00); regRead(toh_pkg::ADDR_ERR_INJ, rd); check(rd, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            regWrite(toh_pkg::ADDR_ERR_INJ, 8'h01 << injBit[i]);
            regRead(toh_pkg::ADDR_ERR_INJ, rd); check(rd, 8'h01 << injBit[i]);
            cr(8'h0B, 8'h00, 8'h00, injKind[i], 1'b0, 1'b0, 4'h1, 3'h0, 1'b1);
            regRead(toh_pkg::ADDR_ERR_INJ, rd); check(rd, 8'h00);
            cr(8'h0B, 8'h00, 8'h00, injKind[i], 1'b0, 1'b0, 4'h1, 3'h0, 1'b0);
        end
        regWrite(toh_pkg::ADDR_ERR_INJ, 8'h06);
        cr(8'h0B, 8'h00, 8'h00, toh_pkg::SLOT_FRAME, 1'b0, 1'b0, 4'h1, 3'h0, 1'b1);
        cr(8'h0B, 8'h00, 8'h00, toh_pkg::SLOT_CRC, 1'b0, 1'b0, 4'h1, 3'h0, 1'b1);
        $display("Test error injection finished");
        cr(8'h00, 8'h03, 8'h00, toh_pkg::SLOT_FE, 1'b1, 1'b0, toh_pkg::FRM_FE13, 3'h0, 1'b1);
        cr(8'h04, 8'h05, 8'h00, toh_pkg::SLOT_FE, 1'b1, 1'b1, toh_pkg::FRM_FE13, 3'h0, 1'b0);
        cr(8'h04, 8'h05, 8'h00, toh_pkg::SLOT_FE, 1'b0, 1'b0, toh_pkg::FRM_FE15, 3'h0, 1'b1);
        pulse(rxCrcErrSmf1);
        pulse(txMfStart);
        cr(8'h04, 8'h00, 8'h00, toh_pkg::SLOT_FE, 1'b1, 1'b1, toh_pkg::FRM_FE13, 3'h0, 1'b0);
        cr(8'h04, 8'h00, 8'h00, toh_pkg::SLOT_FE, 1'b0, 1'b1, toh_pkg::FRM_FE15, 3'h0, 1'b1);
        pulse(rxCrcErrSmf2);
        pulse(txMfStart);
        cr(8'h04, 8'h00, 8'h00, toh_pkg::SLOT_FE, 1'b0, 1'b1, toh_pkg::FRM_FE13, 3'h0, 1'b1);
        cr(8'h04, 8'h00, 8'h00, toh_pkg::SLOT_FE, 1'b1, 1'b1, toh_pkg::FRM_FE15, 3'h0, 1'b0);
        $display("Test far-end bits finished");
        cr(8'h00, 8'h00, 8'h02, toh_pkg::SLOT_YEL, 1'b1, 1'b0, 4'h0, 3'h0, 1'b1);
        cr(8'h10, 8'h00, 8'h00, toh_pkg::SLOT_YEL, 1'b1, 1'b0, 4'h0, 3'h0, 1'b1);
        cr(8'h10, 8'h00, 8'h02, toh_pkg::SLOT_YEL, 1'b1, 1'b0, 4'h0, 3'h0, 1'b0);
        cr(8'h10, 8'h00, 8'h10, toh_pkg::SLOT_YEL, 1'b1, 1'b0, 4'h0, 3'h0, 1'b1);
        rxFrameAlignLost = 1'b1;
        cr(8'h10, 8'h00, 8'h10, toh_pkg::SLOT_YEL, 1'b1, 1'b0, 4'h0, 3'h0, 1'b0);
        cr(8'h20, 8'h00, 8'h04, toh_pkg::SLOT_MYEL, 1'b0, 1'b0, 4'h0, 3'h0, 1'b1);
        cr(8'h20, 8'h00, 8'h20, toh_pkg::SLOT_MYEL, 1'b0, 1'b0, 4'h0, 3'h0, 1'b0);
        rxCasAlignLost = 1'b1;
        cr(8'h20, 8'h00, 8'h20, toh_pkg::SLOT_MYEL, 1'b0, 1'b0, 4'h0, 3'h0, 1'b1);
        cr(8'h00, 8'h00, 8'h24, toh_pkg::SLOT_MYEL, 1'b0, 1'b0, 4'h0, 3'h0, 1'b0);
        cr(8'h00, 8'h20, 8'h00, toh_pkg::SLOT_SPARE, 1'b0, 1'b0, 4'h1, 3'h2, 1'b1);
        cr(8'h00, 8'h20, 8'h00, toh_pkg::SLOT_SPARE, 1'b0, 1'b0, 4'h1, 3'h1, 1'b0);
        $display("Test alarms and spare bits finished");
        t1NotE1Select = 1'b1;
        regWrite(toh_pkg::ADDR_ERR_INJ, 8'h08);
        check({7'h00, alignShiftActive}, 8'h01);
        sendSlot(toh_pkg::SLOT_FRAME, 1'b1, 1'b1, 4'h1, 3'h0, 1'b0); getLine();
        check({7'h00, lastLine.suppress}, 8'h01);
        check({7'h00, alignShiftActive}, 8'h00);
        t1NotE1Select = 1'b0;
        regWrite(toh_pkg::ADDR_ERR_INJ, 8'h18);
        sendSlot(toh_pkg::SLOT_PAYLOAD, 1'b0, 1'b0, 4'h0, 3'h0, 1'b1); getLine();
        check({7'h00, lastLine.extraOne}, 8'h01);
        $display("Test alignment shift finished");
        t1NotE1Select = 1'b1;
        v0 = i_toh_far_end.violations;
        regWrite(toh_pkg::ADDR_ERR_INJ, 8'h01);
        sendSlot(toh_pkg::SLOT_PAYLOAD, 1'b1, 1'b0, 4'h0, 3'h0, 1'b0); getLine();
        sendSlot(toh_pkg::SLOT_PAYLOAD, 1'b0, 1'b0, 4'h0, 3'h0, 1'b0); getLine();
        regRead(toh_pkg::ADDR_ERR_INJ, rd); check(rd & 8'h01, 8'h01);
        check(8'(i_toh_far_end.violations - v0), 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            sendSlot(toh_pkg::SLOT_PAYLOAD, 1'b1, 1'b0, 4'h0, 3'h0, 1'b0);
            getLine();
        end
        regRead(toh_pkg::ADDR_ERR_INJ, rd); check(rd & 8'h01, 8'h00);
        check(8'(i_toh_far_end.violations - v0), 8'h01);
        $display("Test line code violation finished");
        regWrite(toh_pkg::ADDR_ERR_INJ, 8'h00);
        stall = 1'b1;
        for (int i = 0; i < toh_pkg::FIFO_DEPTH; i++)
            sendSlot(toh_pkg::SLOT_PAYLOAD, i[0], 1'b0, 4'h0, 3'h0, 1'b0);
        check({7'h00, slotReady}, 8'h00);
        stall = 1'b0;
        for (int i = 0; i < toh_pkg::FIFO_DEPTH; i++)
        begin
            getLine();
            check({7'h00, lastLine.data}, {7'h00, i[0]});
        end
        $display("Test buffer fill and drain finished");
        closeOut();
    end
endmodule
`default_nettype wire
